/* logic/bmd_map.svh */
`ifndef BMD_MAP_SVH
`define BMD_MAP_SVH

// Register indices and the byte addresses derived from them (index times four).
`define BMD_IDX_DROP_CNT 16'h1c07
`define BMD_IDX_INIT_STS 16'h1c08
`define BMD_IDX_TBL_CMD 16'h1c09
`define BMD_IDX_TBL_WDATA 16'h1c0a
`define BMD_IDX_TBL_RDATA 16'h1c0b
`define BMD_IDX_IRQ_STS 16'h1c10
`define BMD_IDX_IRQ_MASK 16'h1c11
`define BMD_ADDR_DROP_CNT 16'h701c
`define BMD_ADDR_INIT_STS 16'h7020
`define BMD_ADDR_TBL_CMD 16'h7024
`define BMD_ADDR_TBL_WDATA 16'h7028
`define BMD_ADDR_TBL_RDATA 16'h702c
`define BMD_ADDR_IRQ_STS 16'h7040
`define BMD_ADDR_IRQ_MASK 16'h7044

// Field positions.
`define BMD_READY_BIT 0
`define BMD_CMD_DIR_BIT 4
`define BMD_CMD_IDX_MSB 3
`define BMD_PROB_MSB 9
`define BMD_IRQ_DROP_BIT 0
`define BMD_IRQ_READY_BIT 1
`define BMD_IRQ_CMD_BIT 2

// Reset values and counts.
`define BMD_DROP_CNT_RESET 32'h0000_0000
`define BMD_DROP_CNT_MAX 32'hffff_ffff
`define BMD_CMD_DIR_RESET 1'h0
`define BMD_CMD_IDX_RESET 4'h0
`define BMD_PROB_RESET 10'h000
`define BMD_IRQ_RESET 3'h0
`define BMD_INIT_LAST 10'h1ff
`define BMD_LFSR_SEED 10'h001

// Buffer usage boundaries of the discard table ranges.
`define BMD_USE_FINE_END 8'h40
`define BMD_USE_MID_END 8'h80
`define BMD_IDX_MID_BASE 2'h2
`define BMD_IDX_COARSE_BASE 2'h3

`endif

/* logic/bmd_pkg.sv */
package bmd_pkg;

  typedef logic [9:0] bmd_prob_t;
  typedef logic [15:0] bmd_addr_t;
  typedef logic [31:0] bmd_word_t;

  typedef struct packed {
    logic [31:0] drop_count;
    logic tables_initialized_flag;
    logic [9:0] init_count;
    logic table_access_direction;
    logic [3:0] table_index;
    bmd_prob_t discard_table_write_data;
    bmd_prob_t discard_table_read_data;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [9:0] lfsr;
    logic yellow_discard;
    bmd_word_t prdata;
    logic ack;
    logic [15:0][9:0] table_mem;
  } bmd_state_t;

endpackage

/* logic/bmd_discard_ctrl.sv */
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "bmd_map.svh"

// Function
// RULE1 - Count every port 2 drop: space limit, red, or random yellow discard.
// RULE2 - Reading the port 2 drop count returns it and clears it.
// RULE3 - Drop count stops at all ones instead of wrapping.
// RULE4 - Ready flag is zero after fabric reset, self-sets when tables are ready.
// RULE5 - Every fabric reset restarts table initialization, which governs the ready flag.
// RULE6 - Each write to the command register performs one table access.
// RULE7 - A read command loads the selected entry into the read data register.
// RULE8 - Host loads write data before issuing a table write command.
// RULE9 - Command bit 4 picks read (1) or write (0); resets to 0.
// RULE10 - Command bits 3:0 hold the table index; reset to zero.
// RULE11 - Yellow packets use the entry whose range holds ingress used buffers.
// RULE12 - Indices 0 to 7 each cover eight counts, 0 up to 63.
// RULE13 - Indices 8 to 11 cover sixteen counts, 12 to 15 cover thirty-two.
// RULE14 - Selected entry sets the discard probability of the yellow packet.
// RULE15 - Entries are 10-bit probabilities in 1/1024 steps, data bits 9:0.
// RULE16 - Table is not reset; host writes all entries before using discard.
// RULE17 - A drop coinciding with the clearing read is counted after the clear.
module bmd_discard_ctrl (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire bmd_pkg::bmd_addr_t paddr_in,
  input wire bmd_pkg::bmd_word_t pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output bmd_pkg::bmd_word_t prdata_out,
  output logic pslverr_out,
  input wire logic drop_space_in,
  input wire logic drop_red_in,
  input wire logic yellow_pkt_in,
  input wire logic [7:0] used_buffers_in,
  output logic yellow_discard_out,
  output logic tables_initialized_flag_out,
  output logic irq_out
);
  import bmd_pkg::*;

  bmd_state_t st;
  bmd_state_t next_st;

  logic access;
  logic setup_done;
  logic wr_done;
  logic rd_capture;
  logic mapped;
  logic drop_event;
  logic [3:0] usage_index;
  bmd_prob_t usage_prob;
  logic lfsr_feedback;
  bmd_word_t read_mux;
  logic [2:0] irq_set;

  // Access phase waits one cycle so read data comes from a flip-flop; the
  // clear-on-read and the snapshot happen on that same edge.
  assign access = psel_in && penable_in;
  assign rd_capture = access && !st.ack && !pwrite_in;
  assign wr_done = access && st.ack && pwrite_in;
  assign setup_done = access && st.ack;

  always_comb begin
    case (paddr_in)
      `BMD_ADDR_DROP_CNT,
      `BMD_ADDR_INIT_STS,
      `BMD_ADDR_TBL_CMD,
      `BMD_ADDR_TBL_WDATA,
      `BMD_ADDR_TBL_RDATA,
      `BMD_ADDR_IRQ_STS,
      `BMD_ADDR_IRQ_MASK: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Fine ranges at low usage, coarser ones above, so index from the top bits.
  always_comb begin
    if (used_buffers_in < `BMD_USE_FINE_END) begin
      usage_index = {1'b0, used_buffers_in[5:3]}; // RULE12
    end else if (used_buffers_in < `BMD_USE_MID_END) begin
      usage_index = {`BMD_IDX_MID_BASE, used_buffers_in[5:4]}; // RULE13
    end else begin
      usage_index = {`BMD_IDX_COARSE_BASE, used_buffers_in[6:5]}; // RULE13
    end
  end

  assign usage_prob = st.table_mem[usage_index]; // RULE11
  assign lfsr_feedback = st.lfsr[9] ^ st.lfsr[6];

  assign drop_event = drop_space_in || drop_red_in || st.yellow_discard; // RULE1

  always_comb begin
    read_mux = '0;
    case (paddr_in)
      `BMD_ADDR_DROP_CNT: begin
        read_mux = st.drop_count; // RULE2
      end
      `BMD_ADDR_INIT_STS: begin
        read_mux[`BMD_READY_BIT] = st.tables_initialized_flag; // RULE4
      end
      `BMD_ADDR_TBL_CMD: begin
        read_mux[`BMD_CMD_DIR_BIT] = st.table_access_direction;
        read_mux[`BMD_CMD_IDX_MSB:0] = st.table_index;
      end
      `BMD_ADDR_TBL_WDATA: begin
        read_mux[`BMD_PROB_MSB:0] = st.discard_table_write_data;
      end
      `BMD_ADDR_TBL_RDATA: begin
        read_mux[`BMD_PROB_MSB:0] = st.discard_table_read_data; // RULE15
      end
      `BMD_ADDR_IRQ_STS: begin
        read_mux[2:0] = st.irq_status;
      end
      `BMD_ADDR_IRQ_MASK: begin
        read_mux[2:0] = st.irq_mask;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    irq_set = '0;
    next_st.ack = access && !st.ack;
    next_st.lfsr = {st.lfsr[8:0], lfsr_feedback};

    // Yellow decision is registered; probability p drops about p in 1024.
    next_st.yellow_discard = yellow_pkt_in && (st.lfsr < usage_prob); // RULE14

    if (!st.tables_initialized_flag) begin
      next_st.init_count = st.init_count + 10'h001; // RULE5
      if (st.init_count == `BMD_INIT_LAST) begin
        next_st.tables_initialized_flag = 1'b1; // RULE4
        irq_set[`BMD_IRQ_READY_BIT] = 1'b1;
      end
    end

    if (st.drop_count != `BMD_DROP_CNT_MAX) begin
      if (drop_event) begin
        next_st.drop_count = st.drop_count + 32'h0000_0001; // RULE3
      end
    end
    if (drop_event) begin
      irq_set[`BMD_IRQ_DROP_BIT] = 1'b1;
    end

    if (rd_capture) begin
      next_st.prdata = read_mux;
      if (paddr_in == `BMD_ADDR_DROP_CNT) begin
        // A drop in the clearing cycle becomes the first count after it.
        next_st.drop_count = drop_event ? 32'h0000_0001 : 32'h0000_0000; // RULE2 RULE17
      end
    end

    if (wr_done) begin
      case (paddr_in)
        `BMD_ADDR_TBL_CMD: begin
          if (pstrb_in[0]) begin
            next_st.table_access_direction = pwdata_in[`BMD_CMD_DIR_BIT]; // RULE9
            next_st.table_index = pwdata_in[`BMD_CMD_IDX_MSB:0]; // RULE10
            irq_set[`BMD_IRQ_CMD_BIT] = 1'b1;
            if (pwdata_in[`BMD_CMD_DIR_BIT]) begin
              next_st.discard_table_read_data =
                st.table_mem[pwdata_in[`BMD_CMD_IDX_MSB:0]]; // RULE6 RULE7
            end else begin
              // Uses the write data already loaded by software.
              next_st.table_mem[pwdata_in[`BMD_CMD_IDX_MSB:0]] =
                st.discard_table_write_data; // RULE6 RULE8
            end
          end
        end
        `BMD_ADDR_TBL_WDATA: begin
          if (pstrb_in[0]) begin
            next_st.discard_table_write_data[7:0] = pwdata_in[7:0]; // RULE15
          end
          if (pstrb_in[1]) begin
            next_st.discard_table_write_data[`BMD_PROB_MSB:8] =
              pwdata_in[`BMD_PROB_MSB:8]; // RULE15
          end
        end
        `BMD_ADDR_IRQ_STS: begin
          if (pstrb_in[0]) begin
            next_st.irq_status = st.irq_status & ~pwdata_in[2:0];
          end
        end
        `BMD_ADDR_IRQ_MASK: begin
          if (pstrb_in[0]) begin
            next_st.irq_mask = pwdata_in[2:0];
          end
        end
        default: begin
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    next_st.irq_status = next_st.irq_status | irq_set;
  end

  // The discard table is deliberately left out of reset, as in the real RAM.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st.drop_count <= `BMD_DROP_CNT_RESET;
      st.tables_initialized_flag <= 1'b0; // RULE4 RULE5
      st.init_count <= '0;
      st.table_access_direction <= `BMD_CMD_DIR_RESET; // RULE9
      st.table_index <= `BMD_CMD_IDX_RESET; // RULE10
      st.discard_table_write_data <= `BMD_PROB_RESET;
      st.discard_table_read_data <= `BMD_PROB_RESET;
      st.irq_status <= `BMD_IRQ_RESET;
      st.irq_mask <= `BMD_IRQ_RESET;
      st.lfsr <= `BMD_LFSR_SEED;
      st.yellow_discard <= 1'b0;
      st.prdata <= '0;
      st.ack <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign pready_out = st.ack;
  assign pslverr_out = setup_done && !mapped;
  assign prdata_out = st.prdata;
  assign yellow_discard_out = st.yellow_discard;
  assign tables_initialized_flag_out = st.tables_initialized_flag;
  assign irq_out = |(st.irq_status & st.irq_mask);

endmodule

/* sim/bmd_monitor.sv */
`timescale 1ns/100ps
`include "bmd_map.svh"
module bmd_monitor (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire bmd_pkg::bmd_addr_t paddr_in,
  input wire logic pready_out,
  input wire bmd_pkg::bmd_word_t prdata_out,
  input wire logic pslverr_out,
  input wire logic yellow_pkt_in,
  input wire logic yellow_discard_out,
  input wire logic tables_initialized_flag_out
);
  import bmd_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_pready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  a_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready too long");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (pready_out && pslverr_out && !pwrite_in |-> !prdata_out)
    else $error("unmapped read not zero");
  a_ready_low: assert property ($fell(reset_in) |-> !tables_initialized_flag_out [*8])
    else $error("ready early");
  a_ready_holds: assert property (tables_initialized_flag_out |=> tables_initialized_flag_out)
    else $error("ready dropped");
  a_ready_read: assert property (pready_out && !pwrite_in && paddr_in == `BMD_ADDR_INIT_STS
    |-> prdata_out == {31'h0, $past(tables_initialized_flag_out)}) else $error("status mismatch");
  a_discard_cause: assert property (yellow_discard_out |-> $past(yellow_pkt_in))
    else $error("discard without packet");
  c_err: cover property (pready_out && pslverr_out);
  c_discard: cover property (yellow_discard_out);
  c_ready: cover property ($rose(tables_initialized_flag_out));
endmodule

/* sim/testbench.sv */
`timescale 1ns/100ps
`include "bmd_map.svh"
module testbench;
  import bmd_pkg::*;
  logic clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
  logic drop_space_in = 0, drop_red_in = 0, yellow_pkt_in = 0;
  logic pready_out, pslverr_out, yellow_discard_out, tables_initialized_flag_out, irq_out;
  logic [3:0] pstrb_in = 4'hf;
  logic [7:0] used_buffers_in = 8'h00;
  bmd_addr_t paddr_in = 16'h0000;
  bmd_word_t pwdata_in = 32'h0, prdata_out, rd;
  bmd_prob_t tbl [16];
  logic [7:0] cv [6] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hff};
  int failures = 0, n_checks = 0, hits = 0, odd = 0;
  always #50 clk_in = ~clk_in;
  bmd_discard_ctrl uut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out, .drop_space_in,
    .drop_red_in, .yellow_pkt_in, .used_buffers_in, .yellow_discard_out,
    .tables_initialized_flag_out, .irq_out);
  task end_sim;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input bmd_word_t got, input bmd_word_t exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The answer is taken at the rising edge where pready is seen high, then released there.
  task automatic apb(input logic w, input bmd_addr_t a, input bmd_word_t d);
    int i;
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready_out !== 1'b1 && i < 20);
    if (i >= 20) begin
      failures++;
      end_sim();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  function automatic logic [3:0] idx_of(input logic [7:0] u);
    if (u < 8'h40) return {1'b0, u[5:3]};
    if (u < 8'h80) return 4'h8 + u[5:4];
    return 4'hc + u[6:5];
  endfunction
  initial begin
    void'($urandom(17829));
    repeat (20) @(posedge clk_in);
    reset_in <= 0;
    apb(0, `BMD_ADDR_INIT_STS, 0);
    chk(rd, 0);
    repeat (520) @(posedge clk_in);
    apb(0, `BMD_ADDR_INIT_STS, 0);
    chk(rd, 1);
    apb(0, 16'h7100, 0);
    chk({rd[31:1], err}, 1);
    // The second pass leaves odd entries certain and even ones impossible for the discard check.
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 16; k++) begin
        tbl[k] = p ? (k[0] ? 10'h3ff : 10'h000) : 10'($urandom);
        apb(1, `BMD_ADDR_TBL_WDATA, {22'($urandom), tbl[k]});
        apb(1, `BMD_ADDR_TBL_CMD, 32'(k));
        apb(1, `BMD_ADDR_TBL_CMD, 32'h10 | k);
        apb(0, `BMD_ADDR_TBL_CMD, 0);
        chk(rd, 32'h10 | k);
        apb(0, `BMD_ADDR_TBL_RDATA, 0);
        chk(rd, 32'(tbl[k]));
      end
    end
    apb(0, `BMD_ADDR_DROP_CNT, 0);
    apb(1, `BMD_ADDR_IRQ_STS, 7);
    apb(1, `BMD_ADDR_IRQ_MASK, 1);
    @(negedge clk_in);
    chk(32'(irq_out), 0);
    odd = $urandom_range(3, 40);
    repeat (odd) begin
      rd = $urandom;
      @(posedge clk_in);
      drop_space_in <= rd[0] | ~rd[1];
      drop_red_in <= rd[1];
      @(posedge clk_in);
      drop_space_in <= 0;
      drop_red_in <= 0;
    end
    @(negedge clk_in);
    chk(32'(irq_out), 1);
    apb(0, `BMD_ADDR_DROP_CNT, 0);
    chk(rd, 32'(odd));
    apb(1, `BMD_ADDR_IRQ_MASK, 0);
    @(negedge clk_in);
    chk(32'(irq_out), 0);
    apb(1, `BMD_ADDR_IRQ_STS, 1);
    apb(1, `BMD_ADDR_IRQ_MASK, 1);
    @(negedge clk_in);
    chk(32'(irq_out), 0);
    fork
      apb(0, `BMD_ADDR_DROP_CNT, 0);
      begin
        repeat (2) @(posedge clk_in);
        drop_space_in <= 1;
        @(posedge clk_in);
        drop_space_in <= 0;
      end
    join
    chk(rd, 0);
    apb(0, `BMD_ADDR_DROP_CNT, 0);
    chk(rd, 1);
    odd = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_in);
      yellow_pkt_in <= 1;
      used_buffers_in <= (k < 6) ? cv[k] : 8'($urandom);
      @(posedge clk_in);
      yellow_pkt_in <= 0;
      @(negedge clk_in);
      if (idx_of(used_buffers_in) % 2 == 0) chk(32'(yellow_discard_out), 0);
      else begin
        odd++;
        hits += (yellow_discard_out === 1'b1);
      end
    end
    chk(32'(hits >= odd - 1), 1);
    end_sim();
  end
endmodule
bind bmd_discard_ctrl bmd_monitor mon (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pready_out, .prdata_out, .pslverr_out, .yellow_pkt_in, .yellow_discard_out,
  .tables_initialized_flag_out);
